// file: core/pga_pkg.sv
package pga_pkg;

	// ****************************************
	// Register indices (byte address = 4 * index)
	// ****************************************
	localparam int IDX_W = 8;
	localparam int ADDR_LSB = 2;
	localparam logic [IDX_W-1:0] IDX_SETUP = 8'h10;
	localparam logic [IDX_W-1:0] IDX_ALARM = 8'h11;
	localparam logic [IDX_W-1:0] IDX_FAULT = 8'h12;
	localparam logic [IDX_W-1:0] IDX_PRIMARY = 8'h13;
	localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 8'h14;
	localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 8'h15;

	// ****************************************
	// Field layout and reset values
	// ****************************************
	localparam int DATA_W = 32;
	localparam int GAIN_LSB = 0;
	localparam int GAIN_W = 4;
	localparam int SEL_LSB = 4;
	localparam int SEL_W = 3;
	localparam int NUM_GAINS = 12;
	localparam int NUM_ALARMS = 8;
	localparam int SUMMARY_BIT = 4;
	localparam int CRC_BIT = 0;
	localparam int IRQ_W = 2;
	localparam int IRQ_ALARM_BIT = 0;
	localparam int IRQ_CRC_BIT = 1;
	localparam logic [GAIN_W-1:0] GAIN_UNITY = 4'h4;
	localparam logic [GAIN_W-1:0] GAIN_MAX = 4'hb;
	localparam logic [GAIN_W-1:0] GAIN_RESET = 4'h4;
	localparam logic [SEL_W-1:0] SEL_EXTERNAL = 3'h0;
	localparam logic [SEL_W-1:0] SEL_TEST = 3'h5;
	localparam logic [SEL_W-1:0] SEL_RESET = 3'h5;

	function automatic logic pga_gain_ok(input logic [GAIN_W-1:0] code);
		return code <= GAIN_MAX;
	endfunction : pga_gain_ok

	function automatic logic pga_sel_ok(input logic [SEL_W-1:0] code);
		return (code == SEL_EXTERNAL) || (code == SEL_TEST);
	endfunction : pga_sel_ok

endpackage : pga_pkg

// file: core/pga_reg_if.sv
`timescale 1ns/10ps
`default_nettype none
interface pga_reg_if;
	import pga_pkg::*;
	logic setup;
	logic access;
	logic write;
	logic [IDX_W-1:0] idx;
	logic [DATA_W-1:0] wdata;
	logic [DATA_W-1:0] rdata;
	logic [DATA_W-1:0] captured;
	logic mapped;
	modport bus(output setup, access, write, idx, wdata, captured,
		input rdata, mapped);
	modport core(input setup, access, write, idx, wdata, captured,
		output rdata, mapped);
endinterface : pga_reg_if
`default_nettype wire

// file: core/pga_apb_slave.sv
`timescale 1ns/10ps
`default_nettype none
module pga_apb_slave
	import pga_pkg::*;
#(
	parameter int ADDR_W = 10
) (
	input wire logic pclk, // Bus clock
	input wire logic presetn, // Async reset, low
	input wire logic psel, // Select
	input wire logic penable, // Access phase
	input wire logic pwrite, // Direction
	input wire logic [ADDR_W-1:0] paddr, // Byte address
	input wire logic [DATA_W-1:0] pwdata, // Write data
	output logic [DATA_W-1:0] prdata, // Read data
	output logic pready, // Ready
	output logic pslverr, // Error
	pga_reg_if.bus regs // Register strobes
);
	typedef struct packed {
		logic [DATA_W-1:0] rdata;
		logic err;
	} pga_apb_state_type;

	pga_apb_state_type st, next_st;
	logic aligned;

	// ****************************************
	// Decode
	// ****************************************
	assign aligned = (paddr[ADDR_LSB-1:0] == '0)
		&& ((paddr >> (ADDR_LSB + IDX_W)) == '0);
	assign regs.idx = paddr[ADDR_LSB+IDX_W-1:ADDR_LSB];
	assign regs.setup = psel & ~penable;
	assign regs.access = psel & penable & aligned & regs.mapped;
	assign regs.write = pwrite;
	assign regs.wdata = pwdata;
	assign regs.captured = st.rdata;
	assign pready = psel & penable;
	assign prdata = st.rdata;
	assign pslverr = st.err & psel & penable;

	// Read data captured in setup so the access phase answers from a flop
	always_comb begin
		next_st = st;
		if (regs.setup) begin
			next_st.err = ~(aligned & regs.mapped);
			next_st.rdata = (pwrite || !aligned) ? '0 : regs.rdata;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
endmodule : pga_apb_slave
`default_nettype wire

// file: core/pga_alarm_latch.sv
`timescale 1ns/10ps
`default_nettype none
module pga_alarm_latch
	import pga_pkg::*;
#(
	parameter int N = NUM_ALARMS
) (
	input wire logic pclk, // Clock
	input wire logic presetn, // Async reset, low
	input wire logic [N-1:0] monitor, // Comparator outputs
	input wire logic [N-1:0] clear, // Bits to clear
	output logic [N-1:0] flags, // Latched flags
	output logic new_event // A flag newly set
);
	typedef struct packed {
		logic [N-1:0] flags;
		logic ev;
	} pga_latch_state_type;

	pga_latch_state_type st, next_st;

	assign flags = st.flags;
	assign new_event = st.ev;

	// A comparator hit in the clearing cycle wins over the clear
	always_comb begin
		next_st.flags = (st.flags & ~clear) | monitor;
		next_st.ev = |(monitor & ~(st.flags & ~clear));
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
endmodule : pga_alarm_latch
`default_nettype wire

// file: core/pga_front_end.sv
// How it works
// R1: Gain codes 0..11 select 0.0625 to 128
// R2: Below unity attenuates, unity and above amplifies
// R3: Setup register 10h holds input and gain
// R4: Code 000 external inputs, 101 test voltage
// R5: Eight alarm flags, high/low per monitor
// R6: Alarms at 11h, checksum error at 12h
// R7: Summary bit 4 is OR of all
// R8: Alarm flags latch after condition goes away
// R9: Reading alarm register clears latched flags
// R10: Summary clears only when everything is clear
// R11: Single-cycle excursion still sets a flag
// R12: Host polls summary, then reads sources
// R13: Reserved gain and input codes are ignored
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module pga_front_end
	import pga_pkg::*;
#(
	parameter int ADDR_W = 10
) (
	input wire logic pclk, // 40 MHz clock
	input wire logic presetn, // Async reset, low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [ADDR_W-1:0] paddr, // APB byte address
	input wire logic [pga_pkg::DATA_W-1:0] pwdata, // APB write data
	output logic [pga_pkg::DATA_W-1:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error
	input wire logic [pga_pkg::NUM_ALARMS-1:0] monitor_hit, // Comparators
	input wire logic checksum_error_flag, // Checksum error level
	output logic [pga_pkg::GAIN_W-1:0] gain_code, // Active gain code
	output logic [pga_pkg::NUM_GAINS-1:0] gain_onehot, // Gain step
	output logic attenuate_mode, // Gain below unity
	output logic connect_external, // Differential inputs
	output logic connect_test_voltage, // Supply midpoint
	output logic front_end_summary_flag, // Any alarm or error
	output logic irq // Level interrupt
);
	import pga_pkg::*;

	typedef struct packed {
		logic [GAIN_W-1:0] gain;
		logic [SEL_W-1:0] sel;
		logic [NUM_GAINS-1:0] onehot;
		logic atten;
		logic ext;
		logic test;
		logic [IRQ_W-1:0] irq_stat;
		logic [IRQ_W-1:0] irq_mask;
		logic crc_q;
	} pga_core_state_type;

	pga_core_state_type st, next_st;
	pga_reg_if regs();
	logic [NUM_ALARMS-1:0] alarm_flags;
	logic [NUM_ALARMS-1:0] alarm_clear;
	logic alarm_event;
	logic wr;
	logic [GAIN_W-1:0] wr_gain;
	logic [SEL_W-1:0] wr_sel;
	logic [IRQ_W-1:0] irq_event;
	logic [DATA_W-1:0] primary;
	logic bus_ok;

	// ****************************************
	// Bus slave and alarm latch
	// ****************************************
	pga_apb_slave #(.ADDR_W(ADDR_W)) u_apb (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.regs(regs)
	);

	// Only bits returned by the read are cleared, so a hit after setup
	// is not lost
	assign alarm_clear = (regs.access && !regs.write && regs.idx == IDX_ALARM)
		? regs.captured[NUM_ALARMS-1:0] : '0; // R9

	pga_alarm_latch #(.N(NUM_ALARMS)) u_latch (
		.pclk(pclk),
		.presetn(presetn),
		.monitor(monitor_hit), // R5 R11
		.clear(alarm_clear),
		.flags(alarm_flags), // R8
		.new_event(alarm_event)
	);

	// ****************************************
	// Read mux
	// ****************************************
	assign front_end_summary_flag = (|alarm_flags) | checksum_error_flag; // R7 R10

	always_comb begin
		primary = '0;
		primary[SUMMARY_BIT] = front_end_summary_flag; // R7
		regs.rdata = '0;
		regs.mapped = 1'b1;
		unique case (regs.idx)
			IDX_SETUP: begin
				regs.rdata[GAIN_LSB +: GAIN_W] = st.gain; // R3
				regs.rdata[SEL_LSB +: SEL_W] = st.sel;
			end
			IDX_ALARM: regs.rdata[NUM_ALARMS-1:0] = alarm_flags; // R6
			IDX_FAULT: regs.rdata[CRC_BIT] = checksum_error_flag; // R6
			IDX_PRIMARY: regs.rdata = primary;
			IDX_IRQ_STAT: regs.rdata[IRQ_W-1:0] = st.irq_stat;
			IDX_IRQ_MASK: regs.rdata[IRQ_W-1:0] = st.irq_mask;
			default: regs.mapped = 1'b0;
		endcase
	end

	// ****************************************
	// Configuration and interrupt state
	// ****************************************
	assign wr = regs.access & regs.write;
	assign bus_ok = regs.mapped && (paddr[ADDR_LSB-1:0] == '0)
		&& ((paddr >> (ADDR_LSB + IDX_W)) == '0);
	assign wr_gain = regs.wdata[GAIN_LSB +: GAIN_W];
	assign wr_sel = regs.wdata[SEL_LSB +: SEL_W];
	assign irq_event[IRQ_ALARM_BIT] = alarm_event;
	assign irq_event[IRQ_CRC_BIT] = checksum_error_flag & ~st.crc_q;

	always_comb begin
		next_st = st;
		next_st.crc_q = checksum_error_flag;
		if (wr && regs.idx == IDX_SETUP) begin
			if (pga_gain_ok(wr_gain)) begin // R13
				next_st.gain = wr_gain; // R3
			end
			if (pga_sel_ok(wr_sel)) begin // R13
				next_st.sel = wr_sel; // R3
			end
		end
		next_st.onehot = '0;
		next_st.onehot[next_st.gain] = 1'b1; // R1
		next_st.atten = next_st.gain < GAIN_UNITY; // R2
		next_st.ext = next_st.sel == SEL_EXTERNAL; // R4
		next_st.test = next_st.sel == SEL_TEST; // R4
		if (wr && regs.idx == IDX_IRQ_MASK) begin
			next_st.irq_mask = regs.wdata[IRQ_W-1:0];
		end
		if (wr && regs.idx == IDX_IRQ_STAT) begin
			next_st.irq_stat = st.irq_stat & ~regs.wdata[IRQ_W-1:0];
		end
		next_st.irq_stat = next_st.irq_stat | irq_event;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st.gain <= GAIN_RESET;
			st.sel <= SEL_RESET; // R4
			st.onehot <= NUM_GAINS'(1) << GAIN_RESET;
			st.atten <= GAIN_RESET < GAIN_UNITY;
			st.ext <= SEL_RESET == SEL_EXTERNAL;
			st.test <= SEL_RESET == SEL_TEST;
			st.irq_stat <= '0;
			st.irq_mask <= '0;
			st.crc_q <= 1'b0;
		end else begin
			st <= next_st;
		end
	end

	assign gain_code = st.gain;
	assign gain_onehot = st.onehot;
	assign attenuate_mode = st.atten;
	assign connect_external = st.ext;
	assign connect_test_voltage = st.test;
	assign irq = |(st.irq_stat & st.irq_mask);

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	gain_decode_a: assert property ($onehot(gain_onehot) // R1
		&& gain_onehot[gain_code] && gain_code <= GAIN_MAX)
		else $error("gain step does not match gain code");

	atten_mode_a: assert property (attenuate_mode == (gain_code < GAIN_UNITY)) // R2
		else $error("attenuation mode wrong for gain code");

	setup_write_a: assert property (wr && regs.idx == IDX_SETUP // R3
		&& pga_gain_ok(wr_gain) && pga_sel_ok(wr_sel)
		|=> gain_code == $past(wr_gain)
		&& connect_test_voltage == ($past(wr_sel) == SEL_TEST)
		&& connect_external == ($past(wr_sel) == SEL_EXTERNAL))
		else $error("setup write not applied");

	input_select_a: assert property (!(connect_external && connect_test_voltage) // R4 R13
		&& (connect_external || connect_test_voltage))
		else $error("input selection undefined");

	reserved_code_a: assert property (wr && regs.idx == IDX_SETUP // R13
		&& !pga_gain_ok(wr_gain) |=> $stable(gain_code))
		else $error("reserved gain code taken");

	alarm_hold_a: assert property (alarm_flags[0] && alarm_clear[0] == 1'b0 // R8
		|=> alarm_flags[0])
		else $error("alarm flag dropped without read");

	read_clear_a: assert property (alarm_clear != '0 && monitor_hit == '0 // R9
		|=> (alarm_flags & $past(alarm_clear)) == '0)
		else $error("alarm read did not clear flags");

	transient_a: assert property (monitor_hit[7] ##1 !monitor_hit[7] // R11
		|-> alarm_flags[7])
		else $error("brief excursion not latched");

	summary_a: assert property (front_end_summary_flag == // R7 R10
		((alarm_flags != '0) || checksum_error_flag))
		else $error("summary flag wrong");

	irq_level_a: assert property (alarm_event && st.irq_mask[IRQ_ALARM_BIT]
		|=> irq [*2])
		else $error("alarm interrupt not raised");

	fault_read_a: assert property (regs.setup && !pwrite // R6
		&& regs.idx == IDX_FAULT && bus_ok
		|=> prdata[CRC_BIT] == $past(checksum_error_flag))
		else $error("checksum flag not reported");

	// ****************************************
	// Configuration checks
	// ****************************************
	step_mode_a: assert property (attenuate_mode // R1 R2
		== (gain_onehot[GAIN_UNITY-1:0] != '0))
		else $error("gain step and mode disagree");

	sel_reserved_a: assert property (wr && regs.idx == IDX_SETUP // R13
		&& !pga_sel_ok(wr_sel)
		|=> $stable(connect_external) && $stable(connect_test_voltage))
		else $error("reserved input code taken");

	config_hold_a: assert property (!(wr && regs.idx == IDX_SETUP) // R3 R4
		|=> $stable(gain_code) && $stable(connect_external)
		&& $stable(connect_test_voltage))
		else $error("setup changed without a write");

	setup_read_a: assert property (regs.setup && !pwrite // R3
		&& regs.idx == IDX_SETUP && bus_ok
		|=> prdata[GAIN_LSB +: GAIN_W] == $past(gain_code))
		else $error("setup register read wrong");

	// ****************************************
	// Alarm and summary checks
	// ****************************************
	alarm_set_a: assert property (monitor_hit != '0 // R8 R11
		|=> (alarm_flags & $past(monitor_hit)) == $past(monitor_hit))
		else $error("monitor hit not latched");

	alarm_keep_a: assert property ((($past(alarm_flags) // R8
		& ~$past(alarm_clear)) & ~alarm_flags) == '0)
		else $error("alarm flag lost without a read");

	alarm_source_a: assert property (((alarm_flags // R5
		& ~$past(alarm_flags)) & ~$past(monitor_hit)) == '0)
		else $error("alarm flag set with no monitor hit");

	summary_fall_a: assert property ($fell(front_end_summary_flag) // R10
		|-> alarm_flags == '0)
		else $error("summary dropped with an alarm set");

	alarm_read_a: assert property (regs.setup && !pwrite // R6
		&& regs.idx == IDX_ALARM && bus_ok
		|=> prdata[NUM_ALARMS-1:0] == $past(alarm_flags))
		else $error("alarm register read wrong");

	primary_read_a: assert property (regs.setup && !pwrite // R7
		&& regs.idx == IDX_PRIMARY && bus_ok
		|=> prdata[SUMMARY_BIT] == $past(front_end_summary_flag))
		else $error("primary status read wrong");

	// ****************************************
	// Bus and interrupt checks
	// ****************************************
	bad_access_a: assert property (psel && !penable && !bus_ok
		##1 psel && penable |-> pslverr)
		else $error("refused access not flagged");

	good_access_a: assert property (psel && !penable && bus_ok
		##1 psel && penable |-> !pslverr)
		else $error("legal access flagged as error");

	irq_set_a: assert property (irq_event != '0
		|=> (st.irq_stat & $past(irq_event)) == $past(irq_event))
		else $error("interrupt event not recorded");

	irq_clear_a: assert property (wr && regs.idx == IDX_IRQ_STAT
		|=> (st.irq_stat & $past(regs.wdata[IRQ_W-1:0])
		& ~$past(irq_event)) == '0)
		else $error("interrupt status not cleared");

	mask_write_a: assert property (wr && regs.idx == IDX_IRQ_MASK
		|=> st.irq_mask == $past(regs.wdata[IRQ_W-1:0]))
		else $error("interrupt mask not written");

endmodule : pga_front_end
`default_nettype wire

// file: dv/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import pga_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [9:0] paddr = '0;
	logic [DATA_W-1:0] pwdata = '0, prdata;
	logic pready, pslverr, attenuate_mode, connect_external;
	logic connect_test_voltage, front_end_summary_flag, irq;
	logic [NUM_ALARMS-1:0] monitor_hit = '0;
	logic checksum_error_flag = 0;
	logic [GAIN_W-1:0] gain_code, eg, g4;
	logic [NUM_GAINS-1:0] gain_onehot;
	logic [SEL_W-1:0] es, s;
	logic [7:0] v;
	logic [31:0] rd;
	logic err;
	int failures = 0, tests_run = 0;

	always #12.5 pclk = ~pclk;

	pga_front_end #(.ADDR_W(10)) u_dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.monitor_hit(monitor_hit), .checksum_error_flag(checksum_error_flag),
		.gain_code(gain_code), .gain_onehot(gain_onehot),
		.attenuate_mode(attenuate_mode), .connect_external(connect_external),
		.connect_test_voltage(connect_test_voltage),
		.front_end_summary_flag(front_end_summary_flag), .irq(irq));

	// ****************************************
	// Checking and bus tasks
	// ****************************************
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	function automatic logic [31:0] setup_word(input logic [SEL_W-1:0] sel,
		input logic [GAIN_W-1:0] gain);
		setup_word = '0;
		setup_word[SEL_LSB +: SEL_W] = sel;
		setup_word[GAIN_LSB +: GAIN_W] = gain;
	endfunction : setup_word

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : report_and_stop

	task automatic apb(input logic w, input logic [9:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask : apb

	task automatic rd_chk(input logic [9:0] a, input logic [31:0] exp);
		apb(0, a, '0);
		chk(rd, exp);
	endtask : rd_chk

	task automatic pulse(input logic [7:0] val);
		@(posedge pclk);
		monitor_hit <= val;
		@(posedge pclk);
		monitor_hit <= '0;
		repeat (3) @(negedge pclk);
	endtask : pulse

	// ****************************************
	// Test sequence
	// ****************************************
	initial begin
		void'($urandom(32'h7fb8));
		repeat (2) @(posedge pclk);
		presetn <= 1;
		@(negedge pclk);
		chk(gain_code, 4);
		chk(attenuate_mode, 0);
		chk(connect_test_voltage, 1);
		chk(connect_external, 0);
		chk(front_end_summary_flag, 0);
		rd_chk(10'h040, 32'h54);
		eg = 4'h4;
		es = 3'h5;
		for (int g = 0; g < 16; g++) begin
			s = 3'($urandom);
			if (g % 3 == 0) s = (g % 2) ? SEL_EXTERNAL : SEL_TEST;
			g4 = 4'(g);
			apb(1, 10'h040, setup_word(s, g4));
			if (g < 12) eg = g4;
			if (s == 3'h0 || s == 3'h5) es = s;
			@(negedge pclk);
			chk(gain_code, eg);
			chk(gain_onehot, 12'h1 << eg);
			chk(attenuate_mode, eg < 4);
			chk(connect_external, es == 3'h0);
			chk(connect_test_voltage, es == 3'h5);
			rd_chk(10'h040, setup_word(es, eg));
		end
		apb(1, 10'h054, 32'h3);
		for (int i = 0; i < 5; i++) begin
			v = (i == 0) ? 8'hff : 8'($urandom_range(255, 1));
			pulse(v);
			chk(front_end_summary_flag, 1);
			repeat (4) @(posedge pclk);
			chk(irq, 1);
			rd_chk(10'h044, {24'h0, v});
			rd_chk(10'h044, 32'h0);
			@(negedge pclk);
			chk(front_end_summary_flag, 0);
			rd_chk(10'h050, 32'h1);
			apb(1, 10'h050, 32'h1);
			repeat (2) @(negedge pclk);
			chk(irq, 0);
		end
		@(posedge pclk);
		checksum_error_flag <= 1;
		pulse(8'h24);
		rd_chk(10'h048, 32'h1);
		rd_chk(10'h04c, 32'h10);
		rd_chk(10'h044, 32'h24);
		@(negedge pclk);
		chk(front_end_summary_flag, 1);
		rd_chk(10'h050, 32'h3);
		checksum_error_flag <= 0;
		apb(1, 10'h050, 32'h3);
		repeat (2) @(negedge pclk);
		chk(front_end_summary_flag, 0);
		chk(irq, 0);
		apb(1, 10'h054, 32'h0);
		pulse(8'h80);
		chk(irq, 0);
		rd_chk(10'h050, 32'h1);
		apb(1, 10'h050, 32'h1);
		rd_chk(10'h044, 32'h80);
		apb(0, 10'h07c, '0);
		chk(err, 1);
		chk(rd, 0);
		apb(1, 10'h041, 32'h0);
		chk(err, 1);
		rd_chk(10'h040, setup_word(es, eg));
		report_and_stop();
	end

	initial begin
		#(25 * 20000);
		failures++;
		report_and_stop();
	end
endmodule : testbench
`default_nettype wire
